// File: rtl/rqsb_core.sv
// Request stream sideband capture: offset, abort and hint fields
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/100ps
// Functional notes
// R1 - Aligned mode: offset is start lane modulo 4
// R2 - Capture offset and hint on first beat
// R3 - Dword mode: offset field always zero
// R4 - Root Port config packets: offset zero
// R5 - Abort flag nullifies the packet
// R6 - Abort sticky until end of packet
// R7 - Abort sampled only while ready high
// R8 - No abort on non-posted requests
// R9 - Abort never on first beat
// R10 - Endpoint reports aborted packet via error reporting
// R11 - Bit 12 flags hint presence
// R12 - Hint bit zero when hints unused
// R13 - Hint type carries processing-hint value
// R14 - Ignore hint type without hint present
module rqsb_core (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic request_stream_valid_i,
	input wire logic request_stream_ready_i,
	input wire logic request_stream_last_i,
	input wire logic [rqsb_pkg::SB_WIDTH-1:0] request_stream_sideband_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hsel_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output rqsb_pkg::rqsb_fields_t fields_o,
	output logic fields_valid_o,
	output logic nullify_o,
	output logic error_report_o,
	output logic irq_o
);
	import rqsb_pkg::*;

	logic in_pkt_r;
	logic abort_sticky_r;
	rqsb_fields_t fields_r;
	logic fields_valid_r;
	logic nullify_r;
	logic error_report_r;
	logic [1:0] ctrl_r;
	rqsb_events_t status_r;
	logic [2:0] mask_r;
	logic [15:0] abort_count_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [31:0] rdata_r;
	logic beat;
	logic first_beat;
	logic abort_now;
	logic abort_eff;
	logic pkt_end;
	logic bus_req;
	logic [2:0] ev;
	logic wr_ctrl;
	logic wr_status;
	logic wr_mask;
	logic [1:0] ctrl_nxt;
	logic [2:0] mask_nxt;
	rqsb_events_t status_nxt;
	logic [31:0] rdata_nxt;

	// Only sideband bits 14:8 are looked at; byte enables, steering tag,
	// sequence number and parity pass by this block untouched.
	// Hint type reads as zero whenever no hint was flagged.
	// Handshake terms; abort only counts on accepted beats
	assign beat = request_stream_valid_i && request_stream_ready_i;
	assign first_beat = beat && !in_pkt_r;
	// First-beat abort is illegal, so it is not looked at there
	assign abort_now = beat && in_pkt_r && request_stream_sideband_i[SB_ABORT_BIT]; // R7 R9
	assign abort_eff = abort_now || abort_sticky_r; // R6
	// Early termination in the abort beat also ends the packet
	assign pkt_end = beat && request_stream_last_i;

	// Packet framing tracker
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			in_pkt_r <= 1'b0;
		end else if (beat) begin
			in_pkt_r <= !request_stream_last_i;
		end
	end

	// Sticky abort held until the packet closes
	// Dropping the flag mid-packet does not clear the sticky copy
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			abort_sticky_r <= 1'b0;
		end else if (pkt_end) begin
			abort_sticky_r <= 1'b0;
		end else if (abort_now) begin
			abort_sticky_r <= 1'b1; // R6
		end
	end

	// First-beat field capture
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fields_r <= '0;
			fields_valid_r <= 1'b0;
		end else begin
			fields_valid_r <= first_beat;
			if (first_beat) begin
				fields_r.offset <= request_stream_sideband_i[SB_OFFSET_LSB +: 3]; // R2 R1
				fields_r.hint_present <= request_stream_sideband_i[SB_HINT_BIT]; // R2 R11
				// Type forced to zero when no hint is present
				fields_r.hint_type <= request_stream_sideband_i[SB_HINT_BIT] ?
					request_stream_sideband_i[SB_HTYPE_LSB +: 2] : 2'h0; // R14 R13
			end
		end
	end

	// Nullify pulse in the cycle after the last beat of an aborted packet
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			nullify_r <= 1'b0;
		end else begin
			nullify_r <= pkt_end && abort_eff; // R5
		end
	end

	// Error report pulse only in endpoint mode, same timing as nullify
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			error_report_r <= 1'b0;
		end else begin
			error_report_r <= pkt_end && abort_eff && ctrl_r[0]; // R10
		end
	end

	// Aborted packet counter, wraps
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			abort_count_r <= 16'h0000;
		end else if (pkt_end && abort_eff) begin
			abort_count_r <= abort_count_r + 16'h0001;
		end
	end

	// AHB-Lite address phase capture; zero wait states
	// Transfer size and upper address bits are not decoded: whole words only
	assign bus_req = hsel_i && hready_i && htrans_i[1];
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else if (hready_i) begin
			wr_pend_r <= bus_req && hwrite_i;
			wr_addr_r <= haddr_i[7:0];
		end
	end

	// Write decode for the word still in its data phase
	assign wr_ctrl = wr_pend_r && (wr_addr_r == ADDR_CTRL);
	assign wr_status = wr_pend_r && (wr_addr_r == ADDR_STATUS);
	assign wr_mask = wr_pend_r && (wr_addr_r == ADDR_MASK);

	// Next register values; reads use them so a read right behind a write
	// never returns the word that the write is replacing
	assign ctrl_nxt = wr_ctrl ? hwdata_i[1:0] : ctrl_r;
	assign mask_nxt = wr_mask ? hwdata_i[2:0] : mask_r;

	// Control and mask registers
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_r <= CTRL_RESET;
			mask_r <= MASK_RESET;
		end else begin
			ctrl_r <= ctrl_nxt;
			mask_r <= mask_nxt;
		end
	end

	// Sticky status: a new event beats a same-cycle clear
	assign ev = {pkt_end, pkt_end && abort_eff && ctrl_r[0], pkt_end && abort_eff};
	assign status_nxt = (status_r & ~(wr_status ? hwdata_i[2:0] : 3'h0)) | ev;
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			status_r <= '0;
		end else begin
			status_r <= status_nxt;
		end
	end

	// Read mux; unmapped offsets read as zero
	always_comb begin
		unique case (haddr_i[7:0])
			ADDR_CTRL: rdata_nxt = 32'(ctrl_nxt);
			ADDR_FIELDS: rdata_nxt = 32'({fields_valid_r, fields_r});
			ADDR_STATUS: rdata_nxt = 32'(status_nxt);
			ADDR_MASK: rdata_nxt = 32'(mask_nxt);
			ADDR_COUNT: rdata_nxt = 32'(abort_count_r);
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// Read data registered in the address phase so hrdata comes from flops
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (bus_req && !hwrite_i) begin
			rdata_r <= rdata_nxt;
		end
	end

	// Outputs; bus always ready with OKAY
	assign hrdata_o = rdata_r;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign fields_o = fields_r;
	assign fields_valid_o = fields_valid_r;
	assign nullify_o = nullify_r;
	assign error_report_o = error_report_r;
	assign irq_o = |(status_r & mask_r);
endmodule

// File: rtl/rqsb_pkg.sv
// Package for the request stream sideband field capture block
package rqsb_pkg;
	// Sideband field positions
	localparam int SB_OFFSET_LSB = 8;
	localparam int SB_ABORT_BIT = 11;
	localparam int SB_HINT_BIT = 12;
	localparam int SB_HTYPE_LSB = 13;
	localparam int SB_WIDTH = 60;
	localparam int PAYLOAD_WIDTH = 256;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FIELDS = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0C;
	localparam logic [7:0] ADDR_COUNT = 8'h10;
	// Reset values
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [2:0] MASK_RESET = 3'h0;
	// Captured first-beat fields
	typedef struct packed {
		logic [2:0] offset;
		logic hint_present;
		logic [1:0] hint_type;
	} rqsb_fields_t;
	// Status bit layout: 0 aborted, 1 abort reported, 2 packet done
	typedef struct packed {
		logic pkt_done;
		logic abort_rep;
		logic aborted;
	} rqsb_events_t;
endpackage

// File: testbench/rqsb_assertions.sv
// Checker for first-beat capture, sticky abort and bus response
`timescale 1ns/100ps
module rqsb_chk (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic request_stream_valid_i,
	input wire logic request_stream_ready_i,
	input wire logic request_stream_last_i,
	input wire logic [rqsb_pkg::SB_WIDTH-1:0] request_stream_sideband_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire rqsb_pkg::rqsb_fields_t fields_o,
	input wire logic fields_valid_o,
	input wire logic nullify_o,
	input wire logic error_report_o
);
	import rqsb_pkg::*;
	logic busy_r, ab_r, acc, first, abt;
	logic [SB_WIDTH-1:0] sb;
	logic [5:0] want;
	// Accepted beat, first beat, abort seen so far in this packet
	assign sb = request_stream_sideband_i;
	assign acc = request_stream_valid_i & request_stream_ready_i;
	assign first = acc & ~busy_r;
	assign abt = ab_r | (acc & ~first & sb[SB_ABORT_BIT]);
	assign want = {sb[10:8], sb[SB_HINT_BIT], sb[SB_HINT_BIT] ? sb[14:13] : 2'h0};
	// Abort on a first beat never sets the sticky flag
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_r <= 1'b0;
			ab_r <= 1'b0;
		end else if (acc) begin
			busy_r <= ~request_stream_last_i;
			ab_r <= abt & ~request_stream_last_i;
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	property p_fv; first |=> fields_valid_o; endproperty
	a_fv: assert property (p_fv) else $error("fields valid missing");
	property p_nofv; !first |=> !fields_valid_o; endproperty
	a_nofv: assert property (p_nofv) else $error("stray fields valid");
	property p_fd; first |=> fields_o == $past(want); endproperty
	a_fd: assert property (p_fd) else $error("fields wrong");
	property p_hold; !first |=> $stable(fields_o); endproperty
	a_hold: assert property (p_hold) else $error("fields moved");
	property p_nul; acc && request_stream_last_i && abt |=> nullify_o; endproperty
	a_nul: assert property (p_nul) else $error("nullify missing");
	property p_nonul; !(acc && request_stream_last_i && abt) |=> !nullify_o; endproperty
	a_nonul: assert property (p_nonul) else $error("stray nullify");
	property p_er; error_report_o |-> nullify_o; endproperty
	a_er: assert property (p_er) else $error("report without nullify");
	property p_ok; hreadyout_o && !hresp_o; endproperty
	a_ok: assert property (p_ok) else $error("bus not ready or not okay");
	c_abort: cover property (acc && request_stream_last_i && abt);
	c_hint: cover property (first && sb[SB_HINT_BIT]);
	c_report: cover property (error_report_o);
endmodule
bind rqsb_core rqsb_chk u_chk (.*);

// File: testbench/rqsb_core_test.sv
// Testbench for the request stream sideband capture block
`timescale 1ns/100ps
module rqsb_core_test;
	import rqsb_pkg::*;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic ready = 1'b1;
	logic stall = 1'b0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic valid, last, hready, irq, hresp, fv, nul, rep;
	rqsb_fields_t fld;
	logic [SB_WIDTH-1:0] sb;
	logic [31:0] hrdata;
	int err_count = 0;
	int total_checks = 0;
	int fv_count = 0;
	int nul_count = 0;
	int rep_count = 0;
	// Clock and a downstream ready that toggles while stalling
	initial forever #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) ready <= stall ? ~ready : 1'b1;
	// Count the one-cycle pulses while they stand
	always @(posedge mclk_i) begin
		if (fv === 1'b1) begin
			fv_count <= fv_count + 1;
		end
		if (nul === 1'b1) begin
			nul_count <= nul_count + 1;
		end
		if (rep === 1'b1) begin
			rep_count <= rep_count + 1;
		end
	end
	rqsb_req u_req (.mclk_i(mclk_i), .ready_i(ready), .valid_o(valid), .last_o(last), .sb_o(sb));
	rqsb_core DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .request_stream_valid_i(valid),
		.request_stream_ready_i(ready), .request_stream_last_i(last),
		.request_stream_sideband_i(sb), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hsel_i(1'b1), .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .fields_o(fld), .fields_valid_o(fv),
		.nullify_o(nul), .error_report_o(rep), .irq_o(irq));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Single AHB-Lite word transfer, waits on hready in both phases
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= 32'(a);
		do @(posedge mclk_i); while (!hready);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk_i); while (!hready);
		q = hrdata;
		chk(32'(hresp), 32'h0);
	endtask
	task automatic s_fields();
		logic [31:0] q;
		u_req.pkt(6'h2B, 1, 9);
		chk(32'(fld), 32'h1E);
		bus(1'b0, ADDR_FIELDS, '0, q);
		chk(q, 32'h1E);
		u_req.pkt(6'h30, 2, 9);
		chk(32'(fld), 32'h00);
		bus(1'b0, ADDR_FIELDS, '0, q);
		chk(q, 32'h00);
		chk(fv_count, 32'h2);
	endtask
	task automatic s_abort();
		logic [31:0] q;
		bus(1'b1, ADDR_STATUS, 32'h7, q);
		bus(1'b1, ADDR_CTRL, 32'h1, q);
		bus(1'b1, ADDR_MASK, 32'h1, q);
		stall <= 1'b1;
		u_req.pkt(6'h00, 4, 1);
		stall <= 1'b0;
		@(posedge mclk_i);
		chk(32'(irq), 32'h1);
		chk(nul_count, 32'h1);
		chk(rep_count, 32'h1);
		bus(1'b0, ADDR_STATUS, '0, q);
		chk(q, 32'h7);
		bus(1'b0, ADDR_COUNT, '0, q);
		chk(q, 32'h1);
		bus(1'b1, ADDR_STATUS, 32'h7, q);
		@(posedge mclk_i);
		chk(32'(irq), 32'h0);
	endtask
	task automatic s_first();
		logic [31:0] q;
		u_req.pkt(6'h00, 1, 0);
		chk(nul_count, 32'h1);
		bus(1'b0, ADDR_STATUS, '0, q);
		chk(q, 32'h4);
		bus(1'b1, 8'h20, 32'hFFFF, q);
		bus(1'b0, 8'h20, '0, q);
		chk(q, 32'h0);
		bus(1'b0, ADDR_CTRL, '0, q);
		chk(q, 32'h1);
		// Abort in the last beat with endpoint reporting off
		bus(1'b1, ADDR_CTRL, 32'h0, q);
		u_req.pkt(6'h00, 2, 1);
		chk(nul_count, 32'h2);
		chk(rep_count, 32'h1);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Watchdog far beyond the hundred or fewer cycles the tests need
	initial begin
		#100us;
		err_count++;
		finish_test();
	end
	initial begin
		repeat (20) @(posedge mclk_i);
		resetn_i <= 1'b1;
		@(posedge mclk_i);
		s_fields();
		s_abort();
		s_first();
		finish_test();
	end
endmodule

// File: testbench/rqsb_req.sv
// Requester model issuing request packets beat by beat
`timescale 1ns/100ps
module rqsb_req (
	input wire logic mclk_i,
	input wire logic ready_i,
	output logic valid_o = 1'b0,
	output logic last_o = 1'b0,
	output logic [rqsb_pkg::SB_WIDTH-1:0] sb_o = '0
);
	import rqsb_pkg::*;
	// f is {type, hint, offset}; abort only on beat k, then dropped
	task automatic pkt(input logic [5:0] f, input int n, input int k);
		for (int i = 0; i < n; i++) begin
			valid_o <= 1'b1;
			last_o <= (i == n - 1);
			sb_o <= SB_WIDTH'({f[5:3], i == k, f[2:0]}) << SB_OFFSET_LSB;
			do @(posedge mclk_i); while (!ready_i);
		end
		// Released sideband flips so a stale value cannot pass; valid drops and last holds
		valid_o <= 1'b0;
		sb_o <= ~sb_o;
		repeat (3) @(posedge mclk_i);
	endtask
endmodule
